/* File: design/msp_pkg.sv */
`default_nettype none
package msp_pkg;
   // --------------------------------------------------------------
   // register addresses
   // --------------------------------------------------------------
   localparam logic [5:0] A_WAVE = 6'h01;
   localparam logic [5:0] A_AEN = 6'h02;
   localparam logic [5:0] A_RAEN = 6'h03;
   localparam logic [5:0] A_LAEN = 6'h04;
   localparam logic [5:0] A_VAEN = 6'h05;
   localparam logic [5:0] A_RVAEN = 6'h06;
   localparam logic [5:0] A_LVAEN = 6'h07;
   localparam logic [5:0] A_LVAREN = 6'h08;
   localparam logic [5:0] A_MODE = 6'h09;
   localparam logic [5:0] A_IEN = 6'h0a;
   localparam logic [5:0] A_STAT = 6'h0b;
   localparam logic [5:0] A_RSTAT = 6'h0c;
   localparam logic [5:0] A_CUROS = 6'h0d;
   localparam logic [5:0] A_VOLOS = 6'h0e;
   localparam logic [5:0] A_GAIN = 6'h0f;
   localparam logic [5:0] A_PHASE_CALIBRATION = 6'h10;
   localparam logic [5:0] A_APOFS = 6'h11;
   // --------------------------------------------------------------
   // reset values and fields
   // --------------------------------------------------------------
   localparam logic [15:0] RST_MODE = 16'h000c;
   localparam logic [15:0] RST_IEN = 16'h0040;
   localparam logic [5:0] RST_PHASE_CALIBRATION = 6'h0d;
   localparam int MODE_WSEL_LO = 13;
   localparam int CUROS_INTEG = 7;
   localparam logic [1:0] WSEL_POWER = 2'h0;
   localparam logic [1:0] WSEL_CUR = 2'h2;
   localparam logic [1:0] WSEL_VOLT = 2'h3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [4:0] W_WORD = 5'h18;
   localparam logic [4:0] W_HALF = 5'h10;
   localparam logic [4:0] W_BYTE = 5'h08;
   localparam logic [4:0] W_PHASE_CALIBRATION = 5'h06;
   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_CMD = 3'b001,
      ST_WR = 3'b010,
      ST_RD = 3'b100
   } msp_state_t;
   typedef struct packed {
      logic [5:0] addr;
      logic [1:0] idx;
      logic [7:0] data;
   } msp_wbyte_t;
   typedef struct packed {
      logic [23:0] active;
      logic [23:0] apparent;
      logic [23:0] reactive;
   } msp_power_t;
   // --------------------------------------------------------------
   // register geometry
   // --------------------------------------------------------------
   function automatic logic [4:0] reg_bits(input logic [5:0] a);
      if (a >= A_WAVE && a <= A_LVAREN) begin
         return W_WORD;
      end else if (a >= A_MODE && a <= A_RSTAT) begin
         return W_HALF;
      end else if (a == A_APOFS) begin
         return W_HALF;
      end else if (a == A_PHASE_CALIBRATION) begin
         return W_PHASE_CALIBRATION;
      end
      return W_BYTE;
   endfunction : reg_bits
   function automatic logic [1:0] reg_bytes(input logic [5:0] a);
      logic [4:0] w;
      w = reg_bits(a) + 5'h07;
      return w[4:3];
   endfunction : reg_bytes
endpackage : msp_pkg
`default_nettype wire

/* File: design/msp_serial_port.sv */
`timescale 1ns/100ps
`default_nettype none
module msp_serial_port
   import msp_pkg::*;
(
   // system
   input wire logic CLOCK,
   input wire logic RST,
   // serial link
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic DIN,
   output logic DOUT,
   output logic DOUT_OE,
   // metering core
   input wire msp_power_t POWER,
   input wire logic POWER_VALID,
   input wire logic HALF_CYCLE,
   input wire logic [15:0] HALF_CYCLE_COUNT,
   input wire logic [23:0] WAVE_CUR,
   input wire logic [23:0] WAVE_VOLT,
   input wire logic WAVE_VALID,
   input wire logic [15:0] EVENT_FLAGS,
   // configuration
   output logic [15:0] MODE_BITS,
   output logic INTEGRATOR_EN,
   output logic [5:0] CUR_OFFSET,
   output logic [5:0] VOLT_OFFSET,
   output logic [7:0] PGA_GAIN,
   output logic [5:0] PHASE_CAL,
   output logic [15:0] POWER_OFFSET,
   output logic IRQ_REQ
);
   // --------------------------------------------------------------
   // link domain: falling edge
   // --------------------------------------------------------------
   msp_state_t state_ff;
   logic [6:0] sh_ff;
   logic [2:0] bit_ff;
   logic [1:0] idx_ff;
   logic [5:0] addr_ff;
   logic [7:0] byte_in;
   logic last_bit;
   logic last_byte;
   assign byte_in = {sh_ff, DIN};
   assign last_bit = (bit_ff == BIT_LAST);
   assign last_byte = (idx_ff == 2'(reg_bytes(addr_ff) - 2'h1));

   // chip select high resets the port
   // cs falling starts command mode
   always_ff @(negedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         state_ff <= ST_CMD;
         sh_ff <= 7'h00;
         bit_ff <= 3'h0;
         idx_ff <= 2'h0;
         addr_ff <= 6'h00;
      end else begin
         sh_ff <= byte_in[6:0];
         bit_ff <= bit_ff + 3'h1;
         unique case (state_ff)
            ST_CMD: begin
               if (last_bit) begin
                  addr_ff <= byte_in[5:0];
                  idx_ff <= 2'h0;
                  state_ff <= byte_in[7] ? ST_WR : ST_RD;
               end
            end
            ST_WR, ST_RD: begin
               if (last_bit) begin
                  idx_ff <= idx_ff + 2'h1;
                  if (last_byte) begin
                     state_ff <= ST_CMD;
                  end
               end
            end
         endcase
      end
   end

   // events toward the core, kept apart from the cs reset
   logic wr_fire;
   logic rq_fire;
   logic done_fire;
   assign wr_fire = (state_ff == ST_WR) && last_bit && !CS_N;
   assign rq_fire = (state_ff == ST_CMD) && last_bit && !byte_in[7] && !CS_N;
   assign done_fire = (state_ff == ST_RD) && last_bit && last_byte && !CS_N;

   msp_wbyte_t wbyte_ff;
   logic [2:0] tgl_ff;
   logic [5:0] rq_addr_ff;
   // held byte stays still until the next full byte
   // sample on falling edges
   always_ff @(negedge SCLK or posedge RST) begin
      if (RST) begin
         wbyte_ff <= '0;
         tgl_ff <= 3'h0;
         rq_addr_ff <= 6'h00;
      end else begin
         if (wr_fire) begin
            wbyte_ff <= '{addr: addr_ff, idx: idx_ff, data: byte_in};
         end
         if (rq_fire) begin
            rq_addr_ff <= byte_in[5:0];
         end
         tgl_ff <= tgl_ff ^ {done_fire, rq_fire, wr_fire};
      end
   end

   // --------------------------------------------------------------
   // link domain: rising edge
   // --------------------------------------------------------------
   logic [23:0] snap_ff;
   logic [23:0] out_ff;
   logic oe_ff;
   logic [4:0] pad;
   assign pad = 5'(W_WORD - {reg_bytes(addr_ff), 3'h0});
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         oe_ff <= 1'b0;
         out_ff <= 24'h000000;
      end else if (state_ff == ST_RD) begin
         oe_ff <= 1'b1;
         out_ff <= oe_ff ? {out_ff[22:0], 1'b0} : (snap_ff << pad);
      end else begin
         oe_ff <= 1'b0;
      end
   end
   assign DOUT = out_ff[23];
   assign DOUT_OE = oe_ff && (state_ff == ST_RD) && !CS_N;

   // --------------------------------------------------------------
   // crossing into the core
   // --------------------------------------------------------------
   logic [2:0] s1_ff;
   logic [2:0] s2_ff;
   logic [2:0] s3_ff;
   logic wr_ev;
   logic rq_ev;
   logic done_ev;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         s1_ff <= 3'h0;
         s2_ff <= 3'h0;
         s3_ff <= 3'h0;
      end else begin
         s1_ff <= tgl_ff;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   assign wr_ev = s2_ff[0] ^ s3_ff[0];
   assign rq_ev = s2_ff[1] ^ s3_ff[1];
   assign done_ev = s2_ff[2] ^ s3_ff[2];

   // --------------------------------------------------------------
   // configuration registers
   // --------------------------------------------------------------
   logic [15:0] mode_ff;
   logic [15:0] ien_ff;
   logic [7:0] curos_ff;
   logic [7:0] volos_ff;
   logic [7:0] gain_ff;
   logic [5:0] phase_calibration_ff;
   logic [15:0] apofs_ff;
   logic [23:0] merged;
   logic [1:0] lane;
   assign lane = 2'(reg_bytes(wbyte_ff.addr) - 2'h1 - wbyte_ff.idx);

   function automatic logic [23:0] put_byte(input logic [23:0] old,
                                            input logic [1:0] ln,
                                            input logic [7:0] b);
      logic [23:0] r;
      r = old;
      r[{ln, 3'h0} +: 8] = b;
      return r;
   endfunction : put_byte

   always_comb begin
      unique case (wbyte_ff.addr)
         A_MODE: merged = put_byte({8'h00, mode_ff}, lane, wbyte_ff.data);
         A_IEN: merged = put_byte({8'h00, ien_ff}, lane, wbyte_ff.data);
         A_APOFS: merged = put_byte({8'h00, apofs_ff}, lane, wbyte_ff.data);
         default: merged = put_byte(24'h000000, lane, wbyte_ff.data);
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         mode_ff <= RST_MODE;
         ien_ff <= RST_IEN;
         curos_ff <= 8'h00;
         volos_ff <= 8'h00;
         gain_ff <= 8'h00;
         phase_calibration_ff <= RST_PHASE_CALIBRATION;
         apofs_ff <= 16'h0000;
      end else if (wr_ev) begin
         unique case (wbyte_ff.addr)
            A_MODE: mode_ff <= merged[15:0];
            A_IEN: ien_ff <= merged[15:0];
            A_CUROS: curos_ff <= merged[7:0];
            A_VOLOS: volos_ff <= merged[7:0];
            A_GAIN: gain_ff <= merged[7:0];
            A_PHASE_CALIBRATION: phase_calibration_ff <= merged[5:0];
            A_APOFS: apofs_ff <= merged[15:0];
            default: ;
         endcase
      end
   end

   // trims and config outputs, all from flops
   // integrator enable, trim
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         VOLT_OFFSET <= 6'h00;
      end else begin
         VOLT_OFFSET <= 6'(-volos_ff[5:0]);
      end
   end
   assign MODE_BITS = mode_ff;
   assign INTEGRATOR_EN = curos_ff[CUROS_INTEG];
   assign CUR_OFFSET = curos_ff[5:0];
   assign PGA_GAIN = gain_ff;
   assign PHASE_CAL = phase_calibration_ff;
   assign POWER_OFFSET = apofs_ff;

   // --------------------------------------------------------------
   // energy accumulators
   // --------------------------------------------------------------
   logic [23:0] aen_ff;
   logic [23:0] vaen_ff;
   msp_power_t lacc_ff;
   msp_power_t line_ff;
   msp_power_t nxt_lacc;
   logic [15:0] hc_ff;
   logic clr_a;
   logic clr_va;
   logic hc_end;
   assign clr_a = done_ev && (rq_addr_ff == A_RAEN);
   assign clr_va = done_ev && (rq_addr_ff == A_RVAEN);
   assign hc_end = HALF_CYCLE && (hc_ff + 16'h0001 >= HALF_CYCLE_COUNT);

   // a sample in the clear cycle is kept
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         aen_ff <= 24'h000000;
         vaen_ff <= 24'h000000;
      end else begin
         aen_ff <= (clr_a ? 24'h000000 : aen_ff)
                   + (POWER_VALID ? POWER.active : 24'h000000);
         vaen_ff <= (clr_va ? 24'h000000 : vaen_ff)
                    + (POWER_VALID ? POWER.apparent : 24'h000000);
      end
   end

   always_comb begin
      nxt_lacc = lacc_ff;
      if (POWER_VALID) begin
         nxt_lacc.active = lacc_ff.active + POWER.active;
         nxt_lacc.apparent = lacc_ff.apparent + POWER.apparent;
         nxt_lacc.reactive = lacc_ff.reactive + POWER.reactive;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         lacc_ff <= '0;
         line_ff <= '0;
         hc_ff <= 16'h0000;
      end else if (hc_end) begin
         line_ff <= nxt_lacc;
         lacc_ff <= '0;
         hc_ff <= 16'h0000;
      end else begin
         lacc_ff <= nxt_lacc;
         hc_ff <= hc_ff + (HALF_CYCLE ? 16'h0001 : 16'h0000);
      end
   end

   // --------------------------------------------------------------
   // waveform, status, request
   // --------------------------------------------------------------
   logic [23:0] wave_ff;
   logic [15:0] stat_ff;
   logic [1:0] wsel;
   assign wsel = mode_ff[MODE_WSEL_LO +: 2];
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         wave_ff <= 24'h000000;
      end else if (WAVE_VALID) begin
         unique case (wsel)
            WSEL_POWER: wave_ff <= POWER.active;
            WSEL_CUR: wave_ff <= WAVE_CUR;
            WSEL_VOLT: wave_ff <= WAVE_VOLT;
            default: wave_ff <= wave_ff;
         endcase
      end
   end

   // new events win over the clear
   // status read clear
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         stat_ff <= 16'h0000;
         IRQ_REQ <= 1'b0;
      end else begin
         stat_ff <= ((done_ev && rq_addr_ff == A_RSTAT) ? 16'h0000 : stat_ff)
                    | EVENT_FLAGS;
         IRQ_REQ <= |(stat_ff & ien_ff);
      end
   end

   // --------------------------------------------------------------
   // read snapshot
   // --------------------------------------------------------------
   logic [23:0] rd_val;
   always_comb begin
      unique case (rq_addr_ff)
         A_WAVE: rd_val = wave_ff;
         A_AEN, A_RAEN: rd_val = aen_ff;
         A_LAEN: rd_val = line_ff.active;
         A_VAEN, A_RVAEN: rd_val = vaen_ff;
         A_LVAEN: rd_val = line_ff.apparent;
         A_LVAREN: rd_val = line_ff.reactive;
         A_MODE: rd_val = {8'h00, mode_ff};
         A_IEN: rd_val = {8'h00, ien_ff};
         A_STAT, A_RSTAT: rd_val = {8'h00, stat_ff};
         A_CUROS: rd_val = {16'h0000, curos_ff};
         A_VOLOS: rd_val = {16'h0000, volos_ff};
         A_GAIN: rd_val = {16'h0000, gain_ff};
         A_PHASE_CALIBRATION: rd_val = {18'h0, phase_calibration_ff};
         A_APOFS: rd_val = {8'h00, apofs_ff};
         default: rd_val = 24'h000000;
      endcase
   end

   // whole value frozen for the transfer
   // single copy per read
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         snap_ff <= 24'h000000;
      end else if (rq_ev) begin
         snap_ff <= rd_val;
      end
   end
endmodule : msp_serial_port
`default_nettype wire

/* File: dv/msp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module msp_host_model (
   // serial link
   output logic SCLK,
   output logic CS_N,
   output logic DIN,
   input wire logic DOUT,
   input wire logic DOUT_OE
);
   // ----------------------------------------
   // byte engine
   // ----------------------------------------
   // clock idles high and stands still outside frames
   // select rises once everything waits on it, so the link resets take hold
   initial begin
      SCLK = 1'b1;
      CS_N = 1'b0;
      DIN = 1'b0;
      #1;
      CS_N = 1'b1;
   end
   task automatic xbits(input logic [7:0] b, input int nb, input int gap,
                        output logic [7:0] r, output logic oe);
      r = 8'h00;
      oe = 1'b1;
      for (int i = 7; i > 7 - nb; i--) begin
         DIN = b[i];
         #6;
         r[i] = DOUT;
         oe = oe & DOUT_OE;
         SCLK = 1'b0;
         #(i == 8 - nb ? gap : 6);
         SCLK = 1'b1;
      end
   endtask : xbits
   task automatic xfer(input logic w, input logic [5:0] a, input int n,
                       input int cut, input logic [23:0] d,
                       output logic [23:0] q, output logic ok);
      logic [7:0] r;
      logic oe;
      q = 24'h000000;
      ok = 1'b1;
      CS_N = 1'b0;
      #20;
      // command first; reads leave the snapshot 300 ns
      xbits({w, 1'b0, a}, 8, w ? 6 : 300, r, oe);
      for (int k = n - 1; k >= 0; k--) begin
         // write bytes 4.1 us apart, read bytes back to back, msb byte first
         if (w && k != n - 1) #4100;
         xbits(d[8 * k +: 8], k == 0 ? cut : 8, 6, r, oe);
         q[8 * k +: 8] = r;
         ok = ok & oe;
      end
      #20;
      CS_N = 1'b1;
      DIN = ~DIN;
      // write settles before the next command
      #(w ? 4100 : 200);
   endtask : xfer
endmodule : msp_host_model
`default_nettype wire

/* File: dv/msp_serial_port_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module msp_serial_port_chk
   import msp_pkg::*;
(
   // clocks and reset
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic SCLK,
   // serial link
   input wire logic CS_N,
   input wire logic DIN,
   input wire logic DOUT_OE,
   // core side
   input wire logic [15:0] EVENT_FLAGS,
   input wire logic IRQ_REQ,
   input wire logic [15:0] MODE_BITS,
   input wire logic [7:0] PGA_GAIN,
   input wire logic [5:0] PHASE_CAL
);
   // ----------------------------------------
   // frame tracking
   // ----------------------------------------
   logic [5:0] nfall_ff;
   logic [7:0] cmd_ff;
   logic [3:0] idle_ff;
   logic [5:0] rd_len;
   // chip select high clears the count, as it clears the port
   always_ff @(negedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         nfall_ff <= 6'h00;
         cmd_ff <= 8'h00;
      end else begin
         nfall_ff <= nfall_ff + 6'h01;
         if (nfall_ff < 6'h08) begin
            cmd_ff <= {cmd_ff[6:0], DIN};
         end
      end
   end
   always_comb begin
      rd_len = 6'h08;
      if (cmd_ff[5:0] >= 6'h01 && cmd_ff[5:0] <= 6'h08) begin
         rd_len = 6'h18;
      end else if (cmd_ff[5:0] >= 6'h09 && cmd_ff[5:0] <= 6'h0c || cmd_ff[5:0] == 6'h11) begin
         rd_len = 6'h10;
      end
   end
   // writes land a few cycles after the frame, so wait before calling it idle
   always_ff @(posedge CLOCK) begin
      if (RST || !CS_N) begin
         idle_ff <= 4'h0;
      end else if (idle_ff != 4'hf) begin
         idle_ff <= idle_ff + 4'h1;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   cs_release_a: assert property (@(posedge CLOCK) disable iff (RST)
      CS_N |-> !DOUT_OE) else $error("output driven while deselected");
   cmd_quiet_a: assert property (@(negedge SCLK) disable iff (CS_N || RST)
      nfall_ff < 6'h08 |-> !DOUT_OE) else $error("output driven in command byte");
   wr_quiet_a: assert property (@(negedge SCLK) disable iff (CS_N || RST)
      cmd_ff[7] && nfall_ff >= 6'h08 |-> !DOUT_OE) else $error("output driven in write");
   rd_drive_a: assert property (@(negedge SCLK) disable iff (CS_N || RST)
      !cmd_ff[7] && nfall_ff >= 6'h08 && nfall_ff < rd_len + 6'h08 |-> DOUT_OE)
      else $error("output not driven during read");
   rd_end_a: assert property (@(posedge SCLK) disable iff (CS_N || RST)
      !cmd_ff[7] && nfall_ff == rd_len + 6'h08 |-> !DOUT_OE)
      else $error("output held after last read bit");
   irq_event_a: assert property (@(posedge CLOCK) disable iff (RST)
      EVENT_FLAGS[6] |-> ##2 IRQ_REQ) else $error("enabled event gave no request");
   cfg_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
      idle_ff == 4'hf |-> $stable(MODE_BITS) && $stable(PGA_GAIN))
      else $error("configuration changed while idle");
   reset_vals_a: assert property (@(posedge CLOCK) RST |=>
      MODE_BITS == 16'h000c && PHASE_CAL == 6'h0d && !IRQ_REQ)
      else $error("wrong value after reset");
   cover property (@(posedge SCLK) !cmd_ff[7] && nfall_ff == rd_len + 6'h08);
   cover property (@(negedge SCLK) cmd_ff[7] && nfall_ff == 6'h10);
   cover property (@(posedge CLOCK) IRQ_REQ);
endmodule : msp_serial_port_chk
bind msp_serial_port msp_serial_port_chk u_msp_serial_port_chk (
   .CLOCK(CLOCK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN),
   .DOUT_OE(DOUT_OE), .EVENT_FLAGS(EVENT_FLAGS), .IRQ_REQ(IRQ_REQ),
   .MODE_BITS(MODE_BITS), .PGA_GAIN(PGA_GAIN), .PHASE_CAL(PHASE_CAL));
`default_nettype wire

/* File: dv/test_metering_serial_register_port.sv */
`timescale 1ns/100ps
`default_nettype none
module test_metering_serial_register_port
   import msp_pkg::*;
;
   // ----------------------------------------
   // harness
   // ----------------------------------------
   logic CLOCK, RST, SCLK, CS_N, DIN, DOUT, DOUT_OE, dout_w, POWER_VALID, HALF_CYCLE;
   logic WAVE_VALID, INTEGRATOR_EN, IRQ_REQ, ok;
   logic [15:0] HALF_CYCLE_COUNT, EVENT_FLAGS, MODE_BITS, POWER_OFFSET;
   logic [23:0] WAVE_CUR, WAVE_VOLT, q;
   logic [5:0] CUR_OFFSET, VOLT_OFFSET, PHASE_CAL;
   logic [7:0] PGA_GAIN;
   msp_power_t POWER;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   localparam msp_power_t PW = {24'h000005, 24'h000007, 24'h000009};
   localparam logic [5:0] WA [7] = '{A_MODE, A_IEN, A_CUROS, A_VOLOS, A_GAIN, A_PHASE_CALIBRATION, A_APOFS};
   // phase value kept in range; upper bits are junk
   localparam logic [23:0] WD [7] = '{24'h1234, 24'h41, 24'h85, 24'h03, 24'h5a, 24'hdf, 24'hbeef};
   localparam logic [23:0] RB [7] = '{24'h1234, 24'h41, 24'h85, 24'h03, 24'h5a, 24'h1f, 24'hbeef};
   // waveform select codes and what each leaves in the waveform register
   localparam logic [23:0] WM [4] = '{24'h0000, 24'h4000, 24'h6000, 24'h2000};
   localparam logic [23:0] WX [4] = '{24'h000005, 24'h123456, 24'habcdef, 24'habcdef};
   // released line shows a toggling pattern, never the last bit
   assign dout_w = DOUT_OE ? DOUT : CLOCK;
   msp_serial_port u_msp_serial_port (.CLOCK(CLOCK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N),
      .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .POWER(POWER), .POWER_VALID(POWER_VALID),
      .HALF_CYCLE(HALF_CYCLE), .HALF_CYCLE_COUNT(HALF_CYCLE_COUNT), .WAVE_CUR(WAVE_CUR),
      .WAVE_VOLT(WAVE_VOLT), .WAVE_VALID(WAVE_VALID), .EVENT_FLAGS(EVENT_FLAGS),
      .MODE_BITS(MODE_BITS), .INTEGRATOR_EN(INTEGRATOR_EN), .CUR_OFFSET(CUR_OFFSET),
      .VOLT_OFFSET(VOLT_OFFSET), .PGA_GAIN(PGA_GAIN), .PHASE_CAL(PHASE_CAL),
      .POWER_OFFSET(POWER_OFFSET), .IRQ_REQ(IRQ_REQ));
   msp_host_model u_msp_host_model (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(dout_w),
      .DOUT_OE(DOUT_OE));
   always #10 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wcyc(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask : wcyc
   task automatic pulse(input logic pv, input logic hc, input logic wv, input logic [15:0] ev);
      wcyc(1);
      {POWER_VALID, HALF_CYCLE, WAVE_VALID, EVENT_FLAGS} = {pv, hc, wv, ev};
      wcyc(1);
      {POWER_VALID, HALF_CYCLE, WAVE_VALID, EVENT_FLAGS} = 19'h0;
   endtask : pulse
   task automatic wr(input logic [5:0] a, input int n, input logic [23:0] d, input int cut);
      logic [23:0] r;
      logic f;
      wcyc(1);
      u_msp_host_model.xfer(1'b1, a, n, cut, d, r, f);
   endtask : wr
   task automatic rd(input logic [5:0] a, input int n, input logic [23:0] exp);
      logic [23:0] r;
      logic f;
      wcyc(1);
      u_msp_host_model.xfer(1'b0, a, n, 8, 24'h0, r, f);
      chk(r, exp);
      chk({23'h0, f}, 24'h1);
   endtask : rd
   function automatic int nb(input logic [5:0] a);
      if (a >= A_WAVE && a <= A_LVAREN) return 3;
      if (a >= A_MODE && a <= A_RSTAT || a == A_APOFS) return 2;
      return 1;
   endfunction : nb
   function automatic logic [23:0] rv(input logic [5:0] a);
      return a == A_MODE ? 24'h0c : a == A_IEN ? 24'h40 : a == A_PHASE_CALIBRATION ? 24'h0d : 24'h0;
   endfunction : rv
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      {CLOCK, RST, POWER_VALID, HALF_CYCLE, WAVE_VALID, EVENT_FLAGS} = 21'h000000;
      {POWER, HALF_CYCLE_COUNT} = {PW, 16'h0002};
      {WAVE_CUR, WAVE_VOLT} = {24'h123456, 24'habcdef};
      // reset rises after time zero so the link-side async resets see an edge
      #1;
      RST = 1'b1;
      wcyc(12);
      RST = 1'b0;
      for (int a = 1; a <= 17; a++) rd(6'(a), nb(6'(a)), rv(6'(a)));
      rd(6'h3f, 1, 24'h0);
      $display("test reset done");
      for (int i = 0; i < 7; i++) wr(WA[i], nb(WA[i]), WD[i], 8);
      wcyc(4);
      chk(24'(MODE_BITS), 24'h1234);
      chk(24'({INTEGRATOR_EN, CUR_OFFSET}), 24'h45);
      chk(24'(VOLT_OFFSET), 24'h3d);
      chk({PGA_GAIN, POWER_OFFSET}, 24'h5abeef);
      chk(24'(PHASE_CAL), 24'h1f);
      for (int i = 0; i < 7; i++) rd(WA[i], nb(WA[i]), RB[i]);
      $display("test write done");
      wr(A_STAT, 2, 24'hffff, 8);
      wr(A_AEN, 3, 24'hffffff, 8);
      rd(A_STAT, 2, 24'h0);
      rd(A_AEN, 3, 24'h0);
      wr(A_MODE, 2, 24'hab99, 4);
      chk(24'(MODE_BITS), 24'hab34);
      $display("test protect done");
      pulse(1'b0, 1'b0, 1'b0, 16'h0002);
      wcyc(4);
      chk(24'(IRQ_REQ), 24'h0);
      rd(A_STAT, 2, 24'h0002);
      pulse(1'b0, 1'b0, 1'b0, 16'h0040);
      wcyc(4);
      chk(24'(IRQ_REQ), 24'h1);
      rd(A_RSTAT, 2, 24'h0042);
      rd(A_STAT, 2, 24'h0);
      chk(24'(IRQ_REQ), 24'h0);
      $display("test event done");
      pulse(1'b1, 1'b0, 1'b0, 16'h0);
      pulse(1'b1, 1'b0, 1'b0, 16'h0);
      fork
         rd(A_RAEN, 3, 24'h00000a);
         begin
            #600;
            pulse(1'b1, 1'b0, 1'b0, 16'h0);
         end
      join
      rd(A_AEN, 3, 24'h0);
      rd(A_RVAEN, 3, 24'h15);
      rd(A_VAEN, 3, 24'h0);
      for (int i = 0; i < 6; i++) pulse(i / 2 == 1, i / 2 != 1, 1'b0, 16'h0);
      rd(A_LAEN, 3, 24'h0a);
      rd(A_LVAEN, 3, 24'h0e);
      rd(A_LVAREN, 3, 24'h12);
      $display("test energy done");
      // power, current, voltage, then the code that holds the last sample
      for (int i = 0; i < 4; i++) begin
         wr(A_MODE, 2, WM[i], 8);
         pulse(1'b0, 1'b0, 1'b1, 16'h0);
         rd(A_WAVE, 3, WX[i]);
      end
      u_msp_host_model.xfer(1'b0, A_WAVE, 1, 5, 24'h0, q, ok);
      chk(q, 24'h0000a8);
      chk({23'h0, ok}, 24'h1);
      chk(24'(DOUT_OE), 24'h0);
      rd(A_WAVE, 3, 24'habcdef);
      $display("test abort done");
      close_out();
   end
endmodule : test_metering_serial_register_port
`default_nettype wire
